// ==== rtl/agree_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module agree_sync #(
   parameter int WIDTH = 1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;

   // A bit changes only once the last two stages agree
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         sync_out <= '0;
      end else begin
         s1_ff <= async_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
               sync_out[i] <= s3_ff[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== rtl/vid_out_pkg.sv ====
package vid_out_pkg;
   // Register map and field layout
   localparam logic [7:0] OFS_OUTPUT_FORMAT_CONTROL = 8'h03;
   localparam logic [7:0] OFS_EXTENDED_OUTPUT_CONTROL = 8'h04;
   localparam logic [7:0] OFS_FORMAT_STATUS = 8'h06;
   localparam int TIMING_SEL_LSB = 0;
   localparam int WIDTH_SEL_LSB = 2;
   localparam int FORCE_TRI_BIT = 6;
   localparam int BLANK_PASS_BIT = 7;
   localparam int RANGE_BIT = 0;
   localparam int EXTRA_SEL_LSB = 4;
   localparam int REVISION_BIT = 7;
   localparam logic [7:0] RST_OUTPUT_FORMAT_CONTROL = 8'h00;
   localparam logic [7:0] RST_EXTENDED_OUTPUT_CONTROL = 8'h0C;
   localparam logic [7:0] EXT_WRITE_MASK = 8'hF1;
   // Timing styles
   localparam logic [1:0] TIMING_STYLE_A = 2'h0;
   localparam logic [1:0] TIMING_STYLE_B = 2'h1;
   localparam logic [1:0] TIMING_STYLE_C = 2'h2;
   // Width codes
   localparam logic [3:0] WIDTH_10_422 = 4'h0;
   localparam logic [3:0] WIDTH_20_422 = 4'h1;
   localparam logic [3:0] WIDTH_16_422 = 4'h2;
   localparam logic [3:0] WIDTH_8_422 = 4'h3;
   localparam logic [3:0] WIDTH_12_411 = 4'h4;
   localparam logic [2:0] EXTRA_NONE = 3'h0;
   // Video levels, 10-bit
   localparam logic [9:0] STUDIO_Y_MIN = 10'h040;
   localparam logic [9:0] STUDIO_Y_MAX = 10'h3AC;
   localparam logic [9:0] STUDIO_C_MIN = 10'h040;
   localparam logic [9:0] STUDIO_C_MAX = 10'h3C0;
   localparam logic [9:0] FULL_MIN = 10'h004;
   localparam logic [9:0] FULL_MAX = 10'h3FB;
   localparam logic [9:0] SYNC_PRE_ONE = 10'h3FF;
   localparam logic [9:0] SYNC_PRE_ZERO = 10'h000;
   localparam logic [9:0] BLANK_LINE_LAST = 10'h015;
   typedef enum logic [4:0] {
      SEQ_VIDEO = 5'b00001,
      SEQ_ONE = 5'b00010,
      SEQ_ZERO_A = 5'b00100,
      SEQ_ZERO_B = 5'b01000,
      SEQ_FLAGS = 5'b10000
   } sync_seq_t;
endpackage

// ==== rtl/video_output_format_control.sv ====
// Contract
// - Two-bit timing style select; 11 invalid
// - Width 0000: 10-bit 4:2:2, full rate
// - Width 0001: 20-bit 4:2:2, half rate
// - Width 0010: 16-bit 4:2:2, half rate
// - Width 0011: 8-bit 4:2:2, full rate
// - Width 0100: 12-bit 4:1:1; rest unused
// - Force bit tristates drivers despite enable pin
// - Passthrough: blanking lines 1-21 skip filtering
// - Range bit: studio limits or full range
// - Extra pin select 000 tristates twelve pins
// - Revision bit picks sync code formatting
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module video_output_format_control (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic line_locked_clock,
   input wire logic output_enable_n_pin,
   input wire logic [9:0] y_in,
   input wire logic [9:0] c_in,
   input wire logic h_blank,
   input wire logic v_blank,
   input wire logic field_in,
   input wire logic sync_code_req,
   input wire logic [9:0] line_num,
   output logic [19:0] pix_out,
   output logic pix_oe_n,
   output logic [11:0] extra_out,
   output logic extra_oe_n,
   output logic half_rate_line_clock,
   output logic hsync_out,
   output logic vsync_out
);
   import vid_out_pkg::*;

   logic [7:0] fmt_ctrl_ff;
   logic [7:0] ext_ctrl_ff;
   logic llc_s;
   logic oe_pin_n_s;
   logic llc_prev_ff;
   logic llc_rise;
   logic half_tick;
   logic word_tick;
   logic phase_ff;
   logic sync_pend_ff;
   sync_seq_t seq_ff;
   sync_seq_t nxt_seq;
   logic [9:0] y_prev_ff;
   logic [9:0] y_sel;
   logic [10:0] y_sum;
   logic [9:0] y_lim;
   logic [9:0] c_lim;
   logic [9:0] flags_word;
   logic [9:0] narrow_word;
   logic [19:0] nxt_pix;
   logic [1:0] timing_sel;
   logic [3:0] width_sel;
   logic width_ok;
   logic timing_ok;
   logic half_rate_mode;
   logic in_blank_lines;
   logic v_flag;
   logic hs_lvl;
   logic vs_lvl;

   assign timing_sel = fmt_ctrl_ff[TIMING_SEL_LSB +: 2];
   assign width_sel = fmt_ctrl_ff[WIDTH_SEL_LSB +: 4];
   agree_sync #(.WIDTH(2)) u_pin_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .async_in({line_locked_clock, output_enable_n_pin}),
      .sync_out({llc_s, oe_pin_n_s})
   );

   // Register write port
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fmt_ctrl_ff <= RST_OUTPUT_FORMAT_CONTROL;
         ext_ctrl_ff <= RST_EXTENDED_OUTPUT_CONTROL;
      end else if (reg_wr) begin
         if (reg_addr == OFS_OUTPUT_FORMAT_CONTROL) begin
            fmt_ctrl_ff <= reg_wdata;
         end
         if (reg_addr == OFS_EXTENDED_OUTPUT_CONTROL) begin
            // Reserved field keeps its fixed pattern
            ext_ctrl_ff <= (reg_wdata & EXT_WRITE_MASK) |
                           RST_EXTENDED_OUTPUT_CONTROL;
         end
      end
   end

   // Register read port, data one cycle after strobe
   always_ff @(posedge mclk) begin
      if (!rst_n || !reg_rd) begin
         reg_rdata <= 8'h00;
      end else begin
         case (reg_addr)
            OFS_OUTPUT_FORMAT_CONTROL: begin
               reg_rdata <= fmt_ctrl_ff;
            end
            OFS_EXTENDED_OUTPUT_CONTROL: begin
               reg_rdata <= ext_ctrl_ff;
            end
            OFS_FORMAT_STATUS: begin
               reg_rdata <= {4'h0, half_rate_line_clock, ~pix_oe_n,
                             ~width_ok, ~timing_ok};
            end
            default: begin
               reg_rdata <= 8'h00;
            end
         endcase
      end
   end

   // Mode decode
   always_comb begin
      timing_ok = (timing_sel != 2'h3);
      case (width_sel)
         WIDTH_10_422, WIDTH_8_422: begin
            width_ok = 1'b1;
            half_rate_mode = 1'b0;
         end
         WIDTH_20_422, WIDTH_16_422, WIDTH_12_411: begin
            width_ok = 1'b1;
            half_rate_mode = 1'b1;
         end
         default: begin
            width_ok = 1'b0;
            half_rate_mode = 1'b0;
         end
      endcase
   end

   // Edge detect on the sampled line clock
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         llc_prev_ff <= 1'b0;
      end else begin
         llc_prev_ff <= llc_s;
      end
   end

   assign llc_rise = llc_s & ~llc_prev_ff;
   assign half_tick = llc_rise & ~half_rate_line_clock;
   assign word_tick = half_rate_mode ? half_tick : llc_rise;

   // Half-rate clock toggles on each full-rate rise
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         half_rate_line_clock <= 1'b0;
      end else if (llc_rise) begin
         half_rate_line_clock <= ~half_rate_line_clock;
      end
   end

   // Narrow modes alternate chroma then luma words
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         phase_ff <= 1'b0;
      end else if (word_tick) begin
         phase_ff <= ~phase_ff;
      end
   end

   // Luma filter with blanking passthrough
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         y_prev_ff <= 10'h000;
      end else if (word_tick) begin
         y_prev_ff <= y_in;
      end
   end

   assign in_blank_lines = (line_num != 10'h000) &&
                           (line_num <= BLANK_LINE_LAST);
   assign y_sum = {1'b0, y_in} + {1'b0, y_prev_ff};
   always_comb begin
      if (fmt_ctrl_ff[BLANK_PASS_BIT] && in_blank_lines) begin
         y_sel = y_in;
      end else begin
         y_sel = y_sum[10:1];
      end
   end

   // Output range limiting
   always_comb begin
      if (ext_ctrl_ff[RANGE_BIT]) begin
         y_lim = (y_sel < FULL_MIN) ? FULL_MIN :
                 (y_sel > FULL_MAX) ? FULL_MAX : y_sel;
         c_lim = (c_in < FULL_MIN) ? FULL_MIN :
                 (c_in > FULL_MAX) ? FULL_MAX : c_in;
      end else begin
         y_lim = (y_sel < STUDIO_Y_MIN) ? STUDIO_Y_MIN :
                 (y_sel > STUDIO_Y_MAX) ? STUDIO_Y_MAX : y_sel;
         c_lim = (c_in < STUDIO_C_MIN) ? STUDIO_C_MIN :
                 (c_in > STUDIO_C_MAX) ? STUDIO_C_MAX : c_in;
      end
   end

   // Embedded sync flag word with protection bits
   always_comb begin
      if (ext_ctrl_ff[REVISION_BIT]) begin
         v_flag = v_blank;
      end else begin
         v_flag = v_blank | in_blank_lines;
      end
      flags_word = {1'b1, field_in, v_flag, h_blank,
                    v_flag ^ h_blank, field_in ^ h_blank,
                    field_in ^ v_flag, field_in ^ v_flag ^ h_blank,
                    2'b00};
   end

   // A request waits for the next word boundary
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sync_pend_ff <= 1'b0;
      end else if (sync_code_req) begin
         sync_pend_ff <= 1'b1;
      end else if (word_tick && seq_ff == SEQ_VIDEO) begin
         sync_pend_ff <= 1'b0;
      end
   end

   always_comb begin
      nxt_seq = seq_ff;
      if (word_tick) begin
         case (seq_ff)
            SEQ_VIDEO: begin
               if (sync_pend_ff) begin
                  nxt_seq = SEQ_ONE;
               end
            end
            SEQ_ONE: begin
               nxt_seq = SEQ_ZERO_A;
            end
            SEQ_ZERO_A: begin
               nxt_seq = SEQ_ZERO_B;
            end
            SEQ_ZERO_B: begin
               nxt_seq = SEQ_FLAGS;
            end
            SEQ_FLAGS: begin
               nxt_seq = SEQ_VIDEO;
            end
            default: begin
               nxt_seq = SEQ_VIDEO;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         seq_ff <= SEQ_VIDEO;
      end else begin
         seq_ff <= nxt_seq;
      end
   end

   // Word assembly per output width
   always_comb begin
      case (nxt_seq)
         SEQ_ONE: begin
            narrow_word = SYNC_PRE_ONE;
         end
         SEQ_ZERO_A, SEQ_ZERO_B: begin
            narrow_word = SYNC_PRE_ZERO;
         end
         SEQ_FLAGS: begin
            narrow_word = flags_word;
         end
         default: begin
            narrow_word = phase_ff ? y_lim : c_lim;
         end
      endcase
      case (width_sel)
         WIDTH_10_422: begin
            nxt_pix = {10'h000, narrow_word};
         end
         WIDTH_8_422: begin
            nxt_pix = {12'h000, narrow_word[9:2]};
         end
         WIDTH_20_422: begin
            nxt_pix = (nxt_seq == SEQ_VIDEO) ? {y_lim, c_lim} :
                      {narrow_word, narrow_word};
         end
         WIDTH_16_422: begin
            nxt_pix = (nxt_seq == SEQ_VIDEO) ? {4'h0, y_lim[9:2], c_lim[9:2]} :
                      {4'h0, narrow_word[9:2], narrow_word[9:2]};
         end
         WIDTH_12_411: begin
            nxt_pix = {8'h00, y_lim[9:2], c_lim[9:6]};
         end
         default: begin
            nxt_pix = 20'h00000;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pix_out <= 20'h00000;
      end else if (word_tick) begin
         pix_out <= nxt_pix;
      end
   end

   // Driver enables, active low
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pix_oe_n <= 1'b1;
      end else begin
         pix_oe_n <= fmt_ctrl_ff[FORCE_TRI_BIT] | oe_pin_n_s |
                     ~width_ok;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         extra_oe_n <= 1'b1;
         extra_out <= 12'h000;
      end else begin
         extra_oe_n <= (ext_ctrl_ff[EXTRA_SEL_LSB +: 3] == EXTRA_NONE) |
                       fmt_ctrl_ff[FORCE_TRI_BIT] | oe_pin_n_s;
         if (word_tick) begin
            extra_out <= {c_lim, 2'b00};
         end
      end
   end

   // Separate sync pins, style per timing select
   always_comb begin
      case (timing_sel)
         TIMING_STYLE_B: begin
            hs_lvl = ~h_blank;
            vs_lvl = ~v_blank;
         end
         TIMING_STYLE_C: begin
            hs_lvl = h_blank;
            vs_lvl = field_in;
         end
         default: begin
            hs_lvl = h_blank;
            vs_lvl = v_blank;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hsync_out <= 1'b0;
         vsync_out <= 1'b0;
      end else if (word_tick) begin
         hsync_out <= hs_lvl;
         vsync_out <= vs_lvl;
      end
   end
endmodule
`default_nettype wire

// ==== tb/video_output_format_control_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module video_output_format_control_bench;
   import vid_out_pkg::*;
   localparam logic [9:0] Y = 10'h2A4;
   localparam logic [9:0] C = 10'h158;
   logic mclk, rst_n, reg_wr, reg_rd, run, line_locked_clock;
   logic output_enable_n_pin, h_blank, v_blank, field_in, sync_code_req;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [9:0] y_in, c_in, line_num;
   logic [19:0] pix_out;
   logic [11:0] extra_out;
   logic pix_oe_n, extra_oe_n, half_rate_line_clock, hsync_out, vsync_out;
   int err_total = 0;
   int checked = 0;
   video_output_format_control dut (.mclk, .rst_n, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .line_locked_clock, .output_enable_n_pin,
      .y_in, .c_in, .h_blank, .v_blank, .field_in, .sync_code_req,
      .line_num, .pix_out, .pix_oe_n, .extra_out, .extra_oe_n,
      .half_rate_line_clock, .hsync_out, .vsync_out);
   video_sink_model model (.run, .pix_out, .line_locked_clock);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task give_verdict;
      if (err_total == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [39:0] got, input logic [39:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task settle;
      repeat (60) @(posedge mclk);
   endtask
   // Find the preamble and compare the four sync words
   task sync_chk(input logic [9:0] f);
      int i;
      model.words.delete();
      @(posedge mclk);
      sync_code_req <= 1'b1;
      @(posedge mclk);
      sync_code_req <= 1'b0;
      repeat (200) @(posedge mclk);
      i = 0;
      while (i < model.words.size() - 4 && model.words[i][9:0] !== 10'h3FF)
         i++;
      chk({model.words[i][9:0], model.words[i+1][9:0],
         model.words[i+2][9:0], model.words[i+3][9:0]},
         {10'h3FF, 10'h000, 10'h000, f});
   endtask
   // Count averaged luma words after a step in luma
   task pass_chk(input logic [7:0] f, input logic [9:0] ln, input logic e);
      int hits;
      hits = 0;
      wr(8'h03, f);
      line_num <= ln;
      settle;
      model.words.delete();
      y_in <= 10'h100;
      settle;
      foreach (model.words[k]) begin
         if (model.words[k][19:10] === 10'h1D2) hits++;
      end
      chk(hits > 0, e);
      y_in <= Y;
   endtask
   initial begin
      #500us;
      err_total++;
      give_verdict;
   end
   initial begin
      {reg_wr, reg_rd, run, h_blank, v_blank, field_in, sync_code_req} = '0;
      {reg_addr, reg_wdata, output_enable_n_pin} = '0;
      y_in = Y;
      c_in = C;
      line_num = 10'd100;
      rst_n = 1'b0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      rd(8'h03, 8'h00);
      rd(8'h04, 8'h0C);
      wr(8'h10, 8'hFF);
      rd(8'h10, 8'h00);
      wr(8'h03, 8'hFF);
      rd(8'h03, 8'hFF);
      rd(8'h06, 8'h03);
      wr(8'h04, 8'hFD);
      rd(8'h04, 8'hFD);
      wr(8'h04, 8'h0C);
      run <= 1'b1;
      for (int w = 0; w < 16; w++) begin
         wr(8'h03, {2'b00, 4'(w), 2'b00});
         settle;
         chk(pix_oe_n, w > 4);
         case (w)
            0: chk(pix_out === 20'(Y) || pix_out === 20'(C), 1);
            1: chk(pix_out, {Y, C});
            2: chk(pix_out, {4'h0, Y[9:2], C[9:2]});
            3: chk(pix_out === 20'(Y[9:2]) || pix_out === 20'(C[9:2]), 1);
            4: chk(pix_out, {Y[9:2], C[9:6]});
            default: chk(pix_out, 0);
         endcase
      end
      wr(8'h03, 8'h04);
      for (int v = 0; v < 2; v++) begin
         y_in <= v ? 10'h3FF : 10'h000;
         c_in <= v ? 10'h3FF : 10'h000;
         wr(8'h04, 8'h0C);
         settle;
         chk(pix_out, v ? {STUDIO_Y_MAX, STUDIO_C_MAX}
            : {STUDIO_Y_MIN, STUDIO_C_MIN});
         wr(8'h04, 8'h0D);
         settle;
         chk(pix_out, v ? {FULL_MAX, FULL_MAX} : {FULL_MIN, FULL_MIN});
      end
      y_in <= Y;
      c_in <= C;
      wr(8'h04, 8'h0C);
      wr(8'h03, 8'h44);
      settle;
      chk(pix_oe_n, 1);
      wr(8'h03, 8'h04);
      settle;
      chk(pix_oe_n, 0);
      output_enable_n_pin <= 1'b1;
      settle;
      chk({pix_oe_n, extra_oe_n}, 2'b11);
      output_enable_n_pin <= 1'b0;
      wr(8'h04, 8'h1C);
      settle;
      chk({extra_oe_n, extra_out}, {1'b0, C, 2'b00});
      wr(8'h04, 8'h0C);
      settle;
      chk(extra_oe_n, 1);
      wr(8'h03, 8'h00);
      line_num <= 10'd10;
      sync_chk(10'h2AC);
      wr(8'h04, 8'h8C);
      sync_chk(10'h200);
      pass_chk(8'h04, 10'h00A, 1'b1);
      pass_chk(8'h84, 10'h00A, 1'b0);
      pass_chk(8'h84, 10'h064, 1'b1);
      line_num <= 10'd100;
      h_blank <= 1'b1;
      field_in <= 1'b1;
      for (int t = 0; t < 3; t++) begin
         wr(8'h03, 8'(t));
         settle;
         chk(hsync_out, t != 1);
         chk(vsync_out, t != 0);
      end
      h_blank <= 1'b0;
      field_in <= 1'b0;
      run <= 1'b0;
      give_verdict;
   end
endmodule
`default_nettype wire

// ==== tb/video_sink_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module video_sink_model (
   input wire logic run,
   input wire logic [19:0] pix_out,
   output logic line_locked_clock
);
   logic [19:0] words[$];
   // Line clock parks low between frames
   initial begin
      line_locked_clock = 1'b0;
      #3.3;
      forever begin
         #62.5;
         if (run || line_locked_clock) begin
            line_locked_clock = !line_locked_clock;
         end
      end
   end
   // Word from the previous tick, settled by now
   always @(posedge line_locked_clock) begin
      words.push_back(pix_out);
   end
endmodule
`default_nettype wire

// ==== tb/vofc_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module vofc_props (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic line_locked_clock,
   input wire logic output_enable_n_pin,
   input wire logic pix_oe_n,
   input wire logic extra_oe_n,
   input wire logic half_rate_line_clock
);
   import vid_out_pkg::*;
   logic [7:0] fmt_ff;
   logic [7:0] ext_ff;
   // Shadow copies of the two control registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fmt_ff <= RST_OUTPUT_FORMAT_CONTROL;
         ext_ff <= RST_EXTENDED_OUTPUT_CONTROL;
      end else if (reg_wr && reg_addr == OFS_OUTPUT_FORMAT_CONTROL) begin
         fmt_ff <= reg_wdata;
      end else if (reg_wr && reg_addr == OFS_EXTENDED_OUTPUT_CONTROL) begin
         ext_ff <= (reg_wdata & EXT_WRITE_MASK) | 8'h0C;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_force;
      fmt_ff[FORCE_TRI_BIT] [*3] |-> pix_oe_n;
   endproperty
   a_force: assert property (p_force)
      else $error("pixel drivers on while forced off");
   property p_badw;
      (fmt_ff[5:2] > WIDTH_12_411) [*3] |-> pix_oe_n;
   endproperty
   a_badw: assert property (p_badw)
      else $error("pixel drivers on with unused width code");
   property p_oe_follow;
      (!fmt_ff[FORCE_TRI_BIT] && fmt_ff[5:2] <= WIDTH_12_411
         && !output_enable_n_pin) [*7] |-> !pix_oe_n;
   endproperty
   a_oe_follow: assert property (p_oe_follow)
      else $error("pixel drivers off while enabled");
   property p_extra_tri;
      (ext_ff[6:4] == EXTRA_NONE) [*3] |-> extra_oe_n;
   endproperty
   a_extra_tri: assert property (p_extra_tri)
      else $error("extra pins driven with select 000");
   property p_half_src;
      $changed(half_rate_line_clock) |-> $past(line_locked_clock, 2);
   endproperty
   a_half_src: assert property (p_half_src)
      else $error("half clock moved without a line clock rise");
   property p_half_quiet;
      !line_locked_clock [*8] |-> $stable(half_rate_line_clock);
   endproperty
   a_half_quiet: assert property (p_half_quiet)
      else $error("half clock moved while line clock idle");
   property p_rd_fmt;
      reg_rd && reg_addr == OFS_OUTPUT_FORMAT_CONTROL
         |=> reg_rdata == $past(fmt_ff);
   endproperty
   a_rd_fmt: assert property (p_rd_fmt)
      else $error("format register read back wrong");
   property p_rd_ext;
      reg_rd && reg_addr == OFS_EXTENDED_OUTPUT_CONTROL
         |=> reg_rdata == $past(ext_ff) && reg_rdata[3:1] == 3'b110;
   endproperty
   a_rd_ext: assert property (p_rd_ext)
      else $error("extended register read back wrong");
   c_force: cover property (fmt_ff[FORCE_TRI_BIT] && pix_oe_n);
   c_half: cover property ($rose(half_rate_line_clock));
   c_extra: cover property (!extra_oe_n);
endmodule
bind video_output_format_control vofc_props chk (.mclk, .rst_n,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .line_locked_clock, .output_enable_n_pin, .pix_oe_n, .extra_oe_n,
   .half_rate_line_clock);
`default_nettype wire
